// ==== ais_scaler_router.sv ====
// Analog input scaler and router top level
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"
module ais_scaler_router
    import ais_pkg::*;
#(
    parameter int VALUE_W = `AIS_VALUE_W,
    parameter int SETTLE_CYC = `AIS_SETTLE_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Converter sample
    input wire logic sample_valid,
    input wire logic [`AIS_SAMPLE_W-1:0] sample,
    input wire logic sample_under,
    input wire logic sample_over,
    // Settings page
    input wire logic cfg_write,
    input wire logic [7:0] cfg_page,
    input wire ais_cfg_s cfg_data,
    // Panel and serial writers
    input wire logic panel_write,
    input wire logic serial_write,
    input wire logic [2:0] other_dest,
    input wire logic [VALUE_W-1:0] other_value,
    // Destinations
    output ais_val_s target_speed,
    output ais_val_s percent_target,
    output ais_val_s program_num,
    output ais_val_s freqgen_rate,
    output ais_val_s main_tach,
    output ais_val_s leader_tach,
    output logic store_request,
    output logic cfg_error
);
    initial
    begin
        if (VALUE_W != 16)
            $error("VALUE_W must match the settings struct");
    end
    ais_cfg_s cfg;
    ais_cfg_s next_cfg;
    logic next_cfg_error;
    logic [`AIS_SAMPLE_W-1:0] adj;
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic idx_valid;
    logic next_idx_valid;
    logic pot_mode;
    logic route_ok;
    logic settle_accept;
    logic [7:0] settle_held;
    logic map_start;
    logic map_done;
    logic [VALUE_W-1:0] map_result;
    logic map_pending_store;
    logic next_store;
    ais_val_s next_target, next_percent, next_program;
    ais_val_s next_freqgen, next_main, next_leader;

    // Configuration capture
    always_comb
    begin
        next_cfg = cfg;
        next_cfg_error = cfg_error;
        if (cfg_write && cfg_page == `AIS_SETTINGS_PAGE)
        begin
            next_cfg = cfg_data;
            // Only pot source allowed for frequency generator
            next_cfg_error = (cfg_data.dest == AIS_DST_FREQGEN)
                && (cfg_data.source != AIS_SRC_POT);
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg <= '{AIS_DST_NONE, AIS_SRC_POT, 16'h0000, 16'h0000};
            cfg_error <= 1'b0;
        end
        else
        begin
            cfg <= next_cfg;
            cfg_error <= next_cfg_error;
        end
    end

    assign pot_mode = (cfg.source == AIS_SRC_POT);
    assign route_ok = !cfg_error && cfg.dest != AIS_DST_NONE;

    // Sample to step index
    always_comb
    begin
        adj = sample;
        next_idx = idx;
        next_idx_valid = 1'b0;
        if (sample_valid)
        begin
            next_idx_valid = 1'b1;
            if (cfg.source == AIS_SRC_CUR)
            begin
                // Range flags first, then fixed 4 mA reading removed
                adj = sample - `AIS_CUR_OFFSET;
                if (sample_under)
                    next_idx = 8'h00;
                else if (sample_over)
                    next_idx = 8'(`AIS_STEPS_CUR - 1);
                else if (sample < `AIS_CUR_OFFSET)
                    next_idx = 8'h00;
                else if (adj[`AIS_STEP_SHIFT +: 8] > 8'(`AIS_STEPS_CUR - 1))
                    next_idx = 8'(`AIS_STEPS_CUR - 1);
                else
                    next_idx = adj[`AIS_STEP_SHIFT +: 8];
            end
            else if (sample_under)
                next_idx = 8'h00;
            else if (sample_over || sample == `AIS_FULL_SCALE)
                next_idx = 8'(`AIS_STEPS_FULL - 1);
            else
                next_idx = sample[`AIS_STEP_SHIFT +: 8];
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            idx <= 8'h00;
            idx_valid <= 1'b0;
        end
        else
        begin
            idx <= next_idx;
            idx_valid <= next_idx_valid;
        end
    end

    ais_settle #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_settle (
        .clock(clock),
        .rst_n(rst_n),
        .enable(pot_mode && route_ok),
        .sample_valid(idx_valid),
        .index(idx),
        .accept(settle_accept),
        .held(settle_held)
    );

    // Pot waits for settle, others track every sample
    assign map_start = route_ok && (pot_mode ? settle_accept : idx_valid);

    ais_mul_div #(
        .VALUE_W(VALUE_W)
    ) u_map (
        .clock(clock),
        .rst_n(rst_n),
        .start(map_start),
        .index(pot_mode ? settle_held : idx),
        .current_mode(cfg.source == AIS_SRC_CUR),
        .min_value(cfg.min_value),
        .max_value(cfg.max_value),
        .done(map_done),
        .result(map_result)
    );

    // Destination values, last writer wins
    always_comb
    begin
        next_target = target_speed;
        next_percent = percent_target;
        next_program = program_num;
        next_freqgen = freqgen_rate;
        next_main = main_tach;
        next_leader = leader_tach;
        next_target.valid = 1'b0;
        next_percent.valid = 1'b0;
        next_program.valid = 1'b0;
        next_freqgen.valid = 1'b0;
        next_main.valid = 1'b0;
        next_leader.valid = 1'b0;
        next_store = 1'b0;
        if (panel_write || serial_write)
        begin
            case (ais_dst_e'(other_dest))
                AIS_DST_TARGET: next_target = '{1'b1, other_value};
                AIS_DST_PERCENT: next_percent = '{1'b1, other_value};
                AIS_DST_PROGRAM: next_program = '{1'b1, other_value};
                AIS_DST_FREQGEN: next_freqgen = '{1'b1, other_value};
                default: ;
            endcase
        end
        if (map_done && route_ok)
        begin
            next_store = map_pending_store;
            case (cfg.dest)
                AIS_DST_TARGET: next_target = '{1'b1, map_result};
                AIS_DST_PERCENT: next_percent = '{1'b1, map_result};
                AIS_DST_PROGRAM: next_program = '{1'b1, map_result};
                AIS_DST_FREQGEN: next_freqgen = '{1'b1, map_result};
                AIS_DST_MAIN_TACH: next_main = '{1'b1, map_result};
                AIS_DST_LEADER_TACH: next_leader = '{1'b1, map_result};
                default: next_store = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            target_speed <= '0;
            percent_target <= '0;
            program_num <= '0;
            freqgen_rate <= '0;
            main_tach <= '0;
            leader_tach <= '0;
            store_request <= 1'b0;
            map_pending_store <= 1'b0;
        end
        else
        begin
            target_speed <= next_target;
            percent_target <= next_percent;
            program_num <= next_program;
            freqgen_rate <= next_freqgen;
            main_tach <= next_main;
            leader_tach <= next_leader;
            store_request <= next_store;
            map_pending_store <= pot_mode;
        end
    end
endmodule
`default_nettype wire

// ==== ais_consts.svh ====
// Constants for the analog input scaler and router
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH
`define AIS_SAMPLE_W 10
`define AIS_VALUE_W 16
`define AIS_STEPS_FULL 256
`define AIS_STEPS_CUR 192
`define AIS_CUR_OFFSET 10'h0C0
`define AIS_FULL_SCALE 10'h3FF
`define AIS_STEP_SHIFT 2
`define AIS_POT_THRESH 8'h04
`define AIS_SETTLE_MS 1000
`define AIS_CLK_MHZ 250
`define AIS_SETTLE_CYC (`AIS_SETTLE_MS * 1000 * `AIS_CLK_MHZ)
`define AIS_SETTINGS_PAGE 8'h0B
`endif

// ==== ais_pkg.sv ====
// Types for the analog input scaler and router
package ais_pkg;
    typedef enum logic [1:0] {AIS_SRC_POT, AIS_SRC_VOLT, AIS_SRC_CUR} ais_src_e;
    typedef enum logic [2:0] {AIS_DST_NONE, AIS_DST_TARGET, AIS_DST_PERCENT,
        AIS_DST_PROGRAM, AIS_DST_FREQGEN, AIS_DST_MAIN_TACH,
        AIS_DST_LEADER_TACH} ais_dst_e;
    typedef struct packed
    {
        ais_dst_e dest;
        ais_src_e source;
        logic [15:0] min_value;
        logic [15:0] max_value;
    } ais_cfg_s;
    typedef struct packed
    {
        logic valid;
        logic [15:0] value;
    } ais_val_s;
endpackage

// ==== ais_mul_div.sv ====
// Linear map of a step index onto the configured span
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"
module ais_mul_div
    import ais_pkg::*;
#(
    parameter int VALUE_W = `AIS_VALUE_W
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [7:0] index,
    input wire logic current_mode,
    input wire logic [VALUE_W-1:0] min_value,
    input wire logic [VALUE_W-1:0] max_value,
    // Result
    output logic done,
    output logic [VALUE_W-1:0] result
);
    initial
    begin
        if (VALUE_W < 8 || VALUE_W > 24)
            $error("VALUE_W out of range");
    end
    logic [VALUE_W+7:0] product;
    logic [VALUE_W+7:0] quot;
    logic [VALUE_W-1:0] span;
    logic [VALUE_W-1:0] next_result;
    logic next_done;
    always_comb
    begin
        span = (max_value > min_value) ? max_value - min_value : '0;
        product = span * index;
        // Truncated division by the step count minus one
        if (current_mode)
            quot = product / (VALUE_W+8)'(`AIS_STEPS_CUR - 1);
        else
            quot = product / (VALUE_W+8)'(`AIS_STEPS_FULL - 1);
        next_result = min_value + quot[VALUE_W-1:0];
        if (max_value <= min_value)
            next_result = min_value;
        next_done = start;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            done <= 1'b0;
            result <= '0;
        end
        else
        begin
            done <= next_done;
            if (start)
                result <= next_result;
        end
    end
endmodule
`default_nettype wire

// ==== ais_settle.sv ====
// Potentiometer change threshold and settle timer
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"
module ais_settle
    import ais_pkg::*;
#(
    parameter int SETTLE_CYC = `AIS_SETTLE_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Step stream
    input wire logic enable,
    input wire logic sample_valid,
    input wire logic [7:0] index,
    // Accepted step
    output logic accept,
    output logic [7:0] held
);
    initial
    begin
        if (SETTLE_CYC < 1)
            $error("SETTLE_CYC must be positive");
    end
    logic tracking;
    logic [31:0] timer;
    logic [7:0] last;
    logic next_tracking;
    logic [31:0] next_timer;
    logic [7:0] next_last;
    logic [7:0] next_held;
    logic next_accept;
    logic [7:0] diff;
    always_comb
    begin
        diff = (index > held) ? index - held : held - index;
        next_tracking = tracking;
        next_timer = timer;
        next_last = last;
        next_held = held;
        next_accept = 1'b0;
        if (!enable)
        begin
            next_tracking = 1'b0;
            next_timer = '0;
        end
        else if (sample_valid && !tracking)
        begin
            if (diff >= `AIS_POT_THRESH)
            begin
                next_tracking = 1'b1;
                next_last = index;
                next_timer = '0;
            end
        end
        else if (tracking)
        begin
            if (sample_valid && index != last)
            begin
                next_last = index;
                next_timer = '0;
            end
            else if (timer >= 32'(SETTLE_CYC - 1))
            begin
                next_tracking = 1'b0;
                next_held = last;
                next_accept = 1'b1;
            end
            else
                next_timer = timer + 32'h1;
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tracking <= 1'b0;
            timer <= '0;
            last <= '0;
            held <= '0;
            accept <= 1'b0;
        end
        else
        begin
            tracking <= next_tracking;
            timer <= next_timer;
            last <= next_last;
            held <= next_held;
            accept <= next_accept;
        end
    end
endmodule
`default_nettype wire

// ==== ais_scaler_router_props.sv ====
// Assertion checker for the analog input scaler and router
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"
module ais_scaler_router_props
    import ais_pkg::*;
#(
    parameter int VALUE_W = `AIS_VALUE_W,
    parameter int SETTLE_CYC = `AIS_SETTLE_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sample and settings
    input wire logic sample_valid,
    input wire logic [`AIS_SAMPLE_W-1:0] sample,
    input wire logic sample_under,
    input wire logic sample_over,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_page,
    input wire ais_cfg_s cfg_data,
    // Other writers
    input wire logic panel_write,
    input wire logic serial_write,
    input wire logic [2:0] other_dest,
    input wire logic [VALUE_W-1:0] other_value,
    // Destinations
    input wire ais_val_s target_speed,
    input wire ais_val_s percent_target,
    input wire ais_val_s program_num,
    input wire ais_val_s freqgen_rate,
    input wire ais_val_s main_tach,
    input wire ais_val_s leader_tach,
    input wire logic store_request,
    input wire logic cfg_error
);
    ais_cfg_s cfg_q;
    ais_cfg_s next_cfg_q;
    logic [5:0] vld;
    logic live;
    assign vld = {leader_tach.valid, main_tach.valid, freqgen_rate.valid,
        program_num.valid, percent_target.valid, target_speed.valid};
    assign live = cfg_q.dest == AIS_DST_TARGET && cfg_q.source != AIS_SRC_POT;
    // Mirror of the settings page
    always_comb
    begin
        next_cfg_q = cfg_q;
        if (cfg_write && cfg_page == `AIS_SETTINGS_PAGE)
            next_cfg_q = cfg_data;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cfg_q <= '0;
        else
            cfg_q <= next_cfg_q;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_ONE_DEST: assert property ($onehot0(vld))
        else $error("several destinations updated");
    AST_LATENCY: assert property (
        sample_valid && live |-> ##3 target_speed.valid)
        else $error("analog update missing");
    AST_UNDER: assert property (
        sample_valid && sample_under && live
        |-> ##3 target_speed.value == cfg_q.min_value)
        else $error("under range not minimum");
    AST_OVER: assert property (
        sample_valid && sample_over && !sample_under && live
        && cfg_q.min_value < cfg_q.max_value
        |-> ##3 target_speed.value == cfg_q.max_value)
        else $error("over range not maximum");
    AST_RANGE: assert property (
        target_speed.valid && cfg_q.dest == AIS_DST_TARGET
        && !$past(panel_write || serial_write)
        && cfg_q.min_value <= cfg_q.max_value
        |-> target_speed.value >= cfg_q.min_value
        && target_speed.value <= cfg_q.max_value)
        else $error("value outside span");
    AST_FREQ_BLOCK: assert property (cfg_error |-> !freqgen_rate.valid)
        else $error("refused route updated");
    AST_ERR_SET: assert property (
        cfg_write && cfg_page == `AIS_SETTINGS_PAGE
        && cfg_data.dest == AIS_DST_FREQGEN
        && cfg_data.source != AIS_SRC_POT |-> ##[1:2] cfg_error)
        else $error("bad source not flagged");
    AST_NO_SAVE: assert property (
        store_request |-> cfg_q.source == AIS_SRC_POT)
        else $error("save without pot source");
    AST_PANEL: assert property (
        panel_write && other_dest == 3'h1 && !$past(sample_valid, 2)
        |=> target_speed.value == $past(other_value))
        else $error("panel write lost");
    AST_HOLD: assert property (
        !target_speed.valid |-> $stable(target_speed.value))
        else $error("value moved without update");
    cover property (cfg_error);
    cover property (store_request);
    cover property (sample_valid && sample_under && live);
endmodule
bind ais_scaler_router ais_scaler_router_props #(
    .VALUE_W(VALUE_W), .SETTLE_CYC(SETTLE_CYC)) props_u (
    .clock(clock), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample(sample), .sample_under(sample_under), .sample_over(sample_over),
    .cfg_write(cfg_write), .cfg_page(cfg_page), .cfg_data(cfg_data),
    .panel_write(panel_write), .serial_write(serial_write),
    .other_dest(other_dest), .other_value(other_value),
    .target_speed(target_speed), .percent_target(percent_target),
    .program_num(program_num), .freqgen_rate(freqgen_rate),
    .main_tach(main_tach), .leader_tach(leader_tach),
    .store_request(store_request), .cfg_error(cfg_error));
`default_nettype wire

// ==== ais_sink_model.sv ====
// Setpoint and feedback consumer model
`timescale 1ns/1ps
`default_nettype none
module ais_sink_model
    import ais_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Destination updates
    input wire logic [5:0] vld,
    input wire logic [95:0] vals,
    // Latched setpoints
    output logic [15:0] last [6]
);
    // Latch each destination on its update pulse
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            last <= '{default: 16'h0000};
        else
            for (int i = 0; i < 6; i++)
                if (vld[i])
                    last[i] <= vals[16*i +: 16];
    end
endmodule
`default_nettype wire

// ==== ais_scaler_router_tb_top.sv ====
// Testbench for the analog input scaler and router
`timescale 1ns/1ps
`default_nettype none
module ais_scaler_router_tb_top;
    import ais_pkg::*;
    logic clock;
    logic rst_n;
    logic sample_valid;
    logic [9:0] sample;
    logic sample_under;
    logic sample_over;
    logic cfg_write;
    logic [7:0] cfg_page;
    ais_cfg_s cfg_data;
    logic panel_write;
    logic serial_write;
    logic [2:0] other_dest;
    logic [15:0] other_value;
    ais_val_s dv [6];
    logic store_request;
    logic cfg_error;
    logic [5:0] vld;
    logic [95:0] vals;
    logic [15:0] last [6];
    int stores;
    int errors;
    int total_checks;
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            vld[i] = dv[i].valid;
            vals[16*i +: 16] = dv[i].value;
        end
    end
    ais_scaler_router #(.SETTLE_CYC(20)) dut_u (
        .clock(clock), .rst_n(rst_n), .sample_valid(sample_valid),
        .sample(sample), .sample_under(sample_under),
        .sample_over(sample_over), .cfg_write(cfg_write),
        .cfg_page(cfg_page), .cfg_data(cfg_data),
        .panel_write(panel_write), .serial_write(serial_write),
        .other_dest(other_dest), .other_value(other_value),
        .target_speed(dv[0]), .percent_target(dv[1]),
        .program_num(dv[2]), .freqgen_rate(dv[3]),
        .main_tach(dv[4]), .leader_tach(dv[5]),
        .store_request(store_request), .cfg_error(cfg_error));
    ais_sink_model sink_u (.clock(clock), .rst_n(rst_n), .vld(vld),
        .vals(vals), .last(last));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock)
        if (store_request === 1'b1)
            stores++;
    task automatic chk(input string name, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cfg(input logic [2:0] d, input logic [1:0] s,
        input logic [15:0] lo, hi, input logic [7:0] pg);
        @(negedge clock);
        cfg_write = 1'b1;
        cfg_page = pg;
        cfg_data = '{ais_dst_e'(d), ais_src_e'(s), lo, hi};
        @(negedge clock);
        cfg_write = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic smp(input logic [9:0] s, input logic u, o,
        input logic [2:0] d, input logic [15:0] exp);
        logic [5:0] want;
        want = (d == 3'h0) ? 6'h00 : 6'h01 << (d - 3'h1);
        @(negedge clock);
        sample_valid = 1'b1;
        sample = s;
        sample_under = u;
        sample_over = o;
        @(negedge clock);
        sample_valid = 1'b0;
        repeat (2) @(negedge clock);
        chk("route", vld, want);
        if (want != 6'h00)
            chk("value", dv[d - 3'h1].value, exp);
    endtask
    task automatic wr(input logic p, s, input logic [15:0] v);
        @(negedge clock);
        panel_write = p;
        serial_write = s;
        other_dest = 3'h1;
        other_value = v;
        @(negedge clock);
        panel_write = 1'b0;
        serial_write = 1'b0;
        @(negedge clock);
        chk("written", dv[0].value, v);
        chk("consumer", last[0], v);
    endtask
    task automatic sc_volt();
        cfg(3'h1, 2'h1, 16'h0064, 16'h03E8, 8'h0B);
        smp(10'h000, 1'b0, 1'b0, 3'h1, 16'h0064);
        smp(10'h3FF, 1'b0, 1'b0, 3'h1, 16'h03E8);
        smp(10'h200, 1'b0, 1'b0, 3'h1, 16'h0227);
        smp(10'h004, 1'b0, 1'b0, 3'h1, 16'h0067);
        smp(10'h3FF, 1'b1, 1'b0, 3'h1, 16'h0064);
        smp(10'h000, 1'b0, 1'b1, 3'h1, 16'h03E8);
        chk("no save", stores, 0);
    endtask
    task automatic sc_cur();
        cfg(3'h2, 2'h2, 16'h000A, 16'h00C9, 8'h0B);
        smp(10'h0C0, 1'b0, 1'b0, 3'h2, 16'h000A);
        smp(10'h188, 1'b0, 1'b0, 3'h2, 16'h003C);
        smp(10'h3FF, 1'b0, 1'b0, 3'h2, 16'h00C9);
        smp(10'h3FF, 1'b1, 1'b0, 3'h2, 16'h000A);
        smp(10'h000, 1'b0, 1'b1, 3'h2, 16'h00C9);
    endtask
    task automatic sc_route();
        for (int d = 0; d < 7; d++)
        begin
            cfg(3'(d), 2'h1, 16'h0000, 16'h0032, 8'h0B);
            chk("cfg_error", cfg_error, d == 4);
            smp(10'h3FF, 1'b0, 1'b0, (d == 4) ? 3'h0 : 3'(d), 16'h0032);
        end
        cfg(3'h4, 2'h0, 16'h0000, 16'h0032, 8'h0B);
        chk("pot freqgen", cfg_error, 1'b0);
    endtask
    task automatic sc_panel();
        cfg(3'h1, 2'h1, 16'h0000, 16'h00FF, 8'h0B);
        cfg(3'h0, 2'h1, 16'h0000, 16'h0001, 8'h0A);
        smp(10'h3FF, 1'b0, 1'b0, 3'h1, 16'h00FF);
        wr(1'b1, 1'b0, 16'h04D2);
        smp(10'h000, 1'b0, 1'b0, 3'h1, 16'h0000);
        wr(1'b0, 1'b1, 16'h0077);
    endtask
    task automatic sc_pot();
        int n;
        int k;
        cfg(3'h1, 2'h0, 16'h0000, 16'h00FF, 8'h0B);
        @(negedge clock);
        sample_valid = 1'b1;
        sample = 10'h200;
        n = 0;
        k = 0;
        while (vld[0] !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("pot value", dv[0].value, 16'h0080);
        chk("pot save", store_request, 1'b1);
        chk("pot settle", n >= 20, 1'b1);
        @(negedge clock);
        sample = 10'h204;
        repeat (60)
        begin
            @(posedge clock);
            #1;
            k += vld[0];
        end
        chk("pot small", k, 0);
        @(negedge clock);
        sample_valid = 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        print_verdict();
    end
    initial
    begin
        errors = 0;
        total_checks = 0;
        stores = 0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample = 10'h000;
        sample_under = 1'b0;
        sample_over = 1'b0;
        cfg_write = 1'b0;
        cfg_page = 8'h00;
        cfg_data = '0;
        panel_write = 1'b0;
        serial_write = 1'b0;
        other_dest = 3'h0;
        other_value = 16'h0000;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        chk("reset", |vals | cfg_error | store_request, 1'b0);
        sc_volt();
        sc_cur();
        sc_route();
        sc_panel();
        sc_pot();
        print_verdict();
    end
endmodule
`default_nettype wire
